// ---- verilog/smcrc_map.vh ----
// smcrc_map.vh - constants for the serial memory crc unit
// assumes: included by its bare name from the design files
`ifndef SMCRC_MAP_VH
`define SMCRC_MAP_VH
`define SMCRC_POLY8        8'h8C
`define SMCRC_POLY16       16'hA001
`define SMCRC_ZERO8        8'h00
`define SMCRC_ZERO16       16'h0000
`define SMCRC_END_OFFSET   5'h1F
`define SMCRC_ROM_ID       56'h0000_0000_0000_01
`define SMCRC_MODE_NONE    2'h0
`define SMCRC_MODE_RDFIRST 2'h1
`define SMCRC_MODE_RDNEXT  2'h2
`define SMCRC_MODE_WRSP    2'h3
`define SMCRC_ST_IDLE      2'h0
`define SMCRC_ST_HDR       2'h1
`define SMCRC_ST_DATA      2'h2
`endif

// ---- verilog/smcrc_shift.v ----
// smcrc_shift.v - one-byte lsb-first shifter for a reflected crc
// assumes: caller feeds a byte and a current value, result is combinational
`timescale 1ns/1ps
`default_nettype none
module smcrc_shift #(
    parameter W = 16
) (
    input  wire [W-1:0] crc_in,
    input  wire [W-1:0] poly,
    input  wire [7:0]   data_in,
    output wire [W-1:0] crc_out
);
    wire [W-1:0] stage [0:8];
    assign stage[0] = crc_in;
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            // lsb of each byte enters first, as on the line
            wire fb = stage[i][0] ^ data_in[i];
            assign stage[i+1] = fb ? ((stage[i] >> 1) ^ poly) : (stage[i] >> 1);
        end
    endgenerate
    assign crc_out = stage[8];
endmodule
`default_nettype wire

// ---- verilog/smcrc_unit.v ----
// smcrc_unit.v - crc generation for identity rom and 16-bit transfer checks
// assumes: the command machinery presents each byte with a one-cycle strobe,
// marks its kind (header or data) and says when a pass or write begins.
// How it works
// - identity rom top byte holds a fixed check code, not computed live
// - identity check polynomial is x8 + x5 + x4 + 1
// - identity check code is sent exactly as stored, never inverted
// - transfer check polynomial is x16 + x15 + x2 + 1
// - transfer check value always leaves the device complemented
// - first read pass: clear, then command, address, data, counter, tamper bytes
// - later read passes: clear, then data, counter and tamper bytes only
// - scratchpad write: clear, then command, both address bytes, all data
// - write check sent only if writing reached scratchpad offset all ones
// - writes may start anywhere; check covers every following byte
`timescale 1ns/1ps
`default_nettype none
`include "smcrc_map.vh"
module smcrc_unit (
    input  wire        clk,
    input  wire        rst,
    input  wire        start,
    input  wire [1:0]  mode,
    input  wire        byte_valid,
    input  wire        byte_is_hdr,
    input  wire [7:0]  byte_data,
    input  wire [4:0]  sp_offset,
    input  wire        finish,
    output reg  [63:0] rom_id,
    output reg  [15:0] crc_tx,
    output reg         crc_tx_valid,
    output reg         crc_send,
    output reg  [15:0] crc_raw,
    output reg         busy
);
    ////////////////////////////////////////////////////////////////////////
    // identity rom: check byte built once as if lasered at manufacture
    ////////////////////////////////////////////////////////////////////////
    // body value is arbitrary, a stand-in for the factory serial
    parameter [55:0] ROM_BODY = `SMCRC_ROM_ID;

    function [7:0] id_crc;
        input [55:0] body;
        integer k;
        reg [7:0] c;
        begin
            c = `SMCRC_ZERO8;
            for (k = 0; k < 56; k = k + 1) begin
                if (c[0] ^ body[k]) begin
                    c = (c >> 1) ^ `SMCRC_POLY8;
                end else begin
                    c = c >> 1;
                end
            end
            id_crc = c;
        end
    endfunction

    // constant expression: no run-time generator for this code
    localparam [7:0] ID_CHECK = id_crc(ROM_BODY);

    ////////////////////////////////////////////////////////////////////////
    // 16-bit generator
    ////////////////////////////////////////////////////////////////////////
    reg  [1:0]  mode_reg;
    reg  [1:0]  mode_next;
    reg  [1:0]  st_reg;
    reg  [1:0]  st_next;
    reg  [15:0] crc_reg;
    reg  [15:0] crc_next;
    reg         hit_end_reg;
    reg         hit_end_next;
    wire [15:0] crc_shifted;

    // generator states, binary coded
    localparam [1:0] ST_IDLE = `SMCRC_ST_IDLE;
    localparam [1:0] ST_HDR  = `SMCRC_ST_HDR;
    localparam [1:0] ST_DATA = `SMCRC_ST_DATA;

    smcrc_shift #(
        .W(16)
    ) u_shift (
        .crc_in (crc_reg),
        .poly   (`SMCRC_POLY16),
        .data_in(byte_data),
        .crc_out(crc_shifted)
    );

    // header bytes count only where the mode carries a header
    wire hdr_ok = (mode_reg == `SMCRC_MODE_RDFIRST) || (mode_reg == `SMCRC_MODE_WRSP);
    // later read passes drop command and address bytes
    wire take = byte_valid && (st_reg != ST_IDLE) &&
                (byte_is_hdr ? hdr_ok : 1'b1);

    always @* begin
        mode_next    = mode_reg;
        st_next      = st_reg;
        crc_next     = crc_reg;
        hit_end_next = hit_end_reg;
        if (start) begin
            mode_next    = mode;
            crc_next     = `SMCRC_ZERO16;
            hit_end_next = 1'b0;
            st_next      = (mode == `SMCRC_MODE_NONE) ? ST_IDLE : ST_HDR;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    st_next = ST_IDLE;
                end
                ST_HDR, ST_DATA: begin
                    if (take) begin
                        crc_next = crc_shifted;
                        if (!byte_is_hdr) begin
                            st_next = ST_DATA;
                        end
                        // any start offset allowed; end flag sees every data byte
                        if (!byte_is_hdr && mode_reg == `SMCRC_MODE_WRSP &&
                            sp_offset == `SMCRC_END_OFFSET) begin
                            hit_end_next = 1'b1;
                        end
                    end
                    if (finish) begin
                        st_next = ST_IDLE;
                    end
                end
                default: begin
                    st_next = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            mode_reg    <= `SMCRC_MODE_NONE;
            st_reg      <= ST_IDLE;
            crc_reg     <= `SMCRC_ZERO16;
            hit_end_reg <= 1'b0;
        end else begin
            mode_reg    <= mode_next;
            st_reg      <= st_next;
            crc_reg     <= crc_next;
            hit_end_reg <= hit_end_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all registered
    ////////////////////////////////////////////////////////////////////////
    wire ending = finish && !start && (st_reg != ST_IDLE);
    // final byte may arrive with finish, so use the next values
    wire send_ok = (mode_reg != `SMCRC_MODE_WRSP) || hit_end_next;

    always @(posedge clk) begin
        if (rst) begin
            rom_id       <= {`SMCRC_ZERO8, 56'h0000_0000_0000_00};
            crc_tx       <= `SMCRC_ZERO16;
            crc_tx_valid <= 1'b0;
            crc_send     <= 1'b0;
            crc_raw      <= `SMCRC_ZERO16;
            busy         <= 1'b0;
        end else begin
            rom_id       <= {ID_CHECK, ROM_BODY};
            crc_raw      <= crc_next;
            busy         <= (st_next != ST_IDLE);
            crc_tx_valid <= ending;
            crc_send     <= ending && send_ok;
            if (ending) begin
                crc_tx <= ~crc_next;
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/smcrc_unit_sva.sv ----
// assertions on the smcrc_unit ports, bound below
// assumes: one clock, synchronous active-high rst
`timescale 1ns/1ps
`default_nettype none
module smcrc_unit_sva #(
    parameter [55:0] ROM_BODY = 56'h0000_0000_0000_01
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        start,
    input wire logic        finish,
    input wire logic        busy,
    input wire logic        crc_tx_valid,
    input wire logic        crc_send,
    input wire logic [1:0]  mode,
    input wire logic [15:0] crc_tx,
    input wire logic [15:0] crc_raw,
    input wire logic [63:0] rom_id
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rom; !$past(rst) && !$past(rst, 2) |-> rom_id[55:0] == ROM_BODY && $stable(rom_id); endproperty
    a_rom: assert property (p_rom) else $error("rom id not fixed");
    property p_clear; start |=> crc_raw == 16'h0000; endproperty
    a_clear: assert property (p_clear) else $error("no clear on start");
    property p_busy; start && mode != 2'h0 |=> busy; endproperty
    a_busy: assert property (p_busy) else $error("busy missing");
    property p_valid; finish && busy && !start |=> crc_tx_valid ##1 !crc_tx_valid; endproperty
    a_valid: assert property (p_valid) else $error("valid pulse wrong");
    property p_tx; crc_tx_valid |-> crc_tx == ~crc_raw; endproperty
    a_tx: assert property (p_tx) else $error("crc not complemented");
    property p_send; crc_send |-> crc_tx_valid; endproperty
    a_send: assert property (p_send) else $error("send without valid");
    // a reset legitimately clears the held value
    property p_hold; !crc_tx_valid && !$past(rst) |-> $stable(crc_tx); endproperty
    a_hold: assert property (p_hold) else $error("crc_tx moved");
    property p_idle; !busy && !start |=> $stable(crc_raw); endproperty
    a_idle: assert property (p_idle) else $error("crc moved while idle");
endmodule
bind smcrc_unit smcrc_unit_sva #(.ROM_BODY(ROM_BODY)) u_sva (.clk(clk), .rst(rst), .start(start),
    .finish(finish), .busy(busy), .crc_tx_valid(crc_tx_valid), .crc_send(crc_send), .mode(mode),
    .crc_tx(crc_tx), .crc_raw(crc_raw), .rom_id(rom_id));
`default_nettype wire

// ---- dv/smcrc_master.sv ----
// bus master model: checks the identity check byte
// assumes: rom_id settled after reset
`timescale 1ns/1ps
`default_nettype none
module smcrc_master (
    input  wire logic [63:0] rom_id,
    output logic             id_ok
);
    function automatic [7:0] smcrc_c8(input [55:0] b);
        integer j;
        smcrc_c8 = 8'h00;
        for (j = 0; j < 56; j++) begin
            smcrc_c8 = (smcrc_c8[0] ^ b[j]) ? (smcrc_c8 >> 1) ^ 8'h8C : smcrc_c8 >> 1;
        end
    endfunction
    assign id_ok = smcrc_c8(rom_id[55:0]) === rom_id[63:56];
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for smcrc_unit with a reference crc model
// assumes: byte strobes driven 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 0, rst = 1, start = 0, byte_valid = 0, byte_is_hdr = 0, finish = 0;
    logic [1:0]  mode = 0;
    logic [7:0]  byte_data = 0;
    logic [4:0]  sp_offset = 0;
    wire  [63:0] rom_id;
    wire  [15:0] crc_tx, crc_raw;
    wire         crc_tx_valid, crc_send, busy, id_ok;
    integer      n_errors = 0, checks = 0, seed = 32'h189d, crc, i, k, last_tx = 0;
    smcrc_unit u_smcrc_unit (.clk(clk), .rst(rst), .start(start), .mode(mode), .byte_valid(byte_valid),
        .byte_is_hdr(byte_is_hdr), .byte_data(byte_data), .sp_offset(sp_offset), .finish(finish),
        .rom_id(rom_id), .crc_tx(crc_tx), .crc_tx_valid(crc_tx_valid), .crc_send(crc_send),
        .crc_raw(crc_raw), .busy(busy));
    smcrc_master u_smcrc_master (.rom_id(rom_id), .id_ok(id_ok));
    initial forever #20 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input [63:0] exp, input [63:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    // model skips header bytes on later read passes, and every byte when idle
    task automatic put(input hdr, input [7:0] d, input [4:0] o, input fin);
        @(posedge clk);
        #1;
        start = 0;
        byte_valid = 1;
        byte_is_hdr = hdr;
        byte_data = d;
        sp_offset = o;
        finish = fin;
        if (mode != 2'h0 && !(mode == 2'h2 && hdr)) begin
            for (k = 0; k < 8; k++) begin
                crc = ((crc ^ d[k]) & 1) ? (crc >> 1) ^ 16'hA001 : crc >> 1;
            end
        end
    endtask
    // mode 0 leaves the unit idle: no answer, held value kept
    task automatic run(input [1:0] m, input integer s, input integer e);
        @(posedge clk);
        #1;
        start = 1;
        mode = m;
        byte_valid = 0;
        finish = 0;
        crc = 0;
        put(1, m == 2'h3 ? 8'h0F : 8'hA5, 5'h00, 0);
        put(1, $random(seed), 5'h00, 0);
        put(1, $random(seed), 5'h00, 0);
        for (i = s; i <= e; i++) begin
            put(0, $random(seed), i, i == e);
        end
        @(posedge clk);
        #1;
        byte_valid = 0;
        finish = 0;
        if (m != 2'h0) begin
            last_tx = ~crc & 16'hFFFF;
        end
        chk("crc_tx_valid", m != 2'h0, crc_tx_valid);
        chk("crc_tx", last_tx, crc_tx);
        chk("crc_raw", crc, crc_raw);
        chk("busy", 0, busy);
        chk("crc_send", m != 2'h0 && (m != 2'h3 || e == 31), crc_send);
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 0;
        @(posedge clk);
        #1;
        chk("rom_body", 56'h0000_0000_0000_01, rom_id[55:0]);
        chk("id_ok", 1, id_ok);
        run(2'h3, 0, 31);
        run(2'h3, 12, 31);
        run(2'h3, 3, 30);
        run(2'h0, 0, 31);
        run(2'h1, 0, 31);
        run(2'h2, 0, 31);
        run(2'h2, 30, 31);
        run(2'h1, 7, 9);
        // reset while a pass is open, held for two edges
        @(posedge clk);
        #1;
        start = 1;
        mode = 2'h1;
        @(posedge clk);
        #1;
        start = 0;
        rst = 1;
        repeat (2) @(posedge clk);
        #1;
        last_tx = 0;
        chk("rom_id_rst", 0, rom_id);
        chk("crc_tx_rst", 0, crc_tx);
        chk("busy_rst", 0, busy);
        rst = 0;
        @(posedge clk);
        #1;
        chk("rom_body", 56'h0000_0000_0000_01, rom_id[55:0]);
        chk("id_ok", 1, id_ok);
        run(2'h3, 31, 31);
        run(2'h2, 5, 9);
        wrap_up;
    end
endmodule
`default_nettype wire
